// ---- rtl/dual_counter_map.svh ----
// Purpose: constants for the dual counter with capture readout
// Assumes: included by its bare name
// Notes: times in ns, counts derived from the clock period
`ifndef DUAL_COUNTER_MAP_SVH
`define DUAL_COUNTER_MAP_SVH
`define CNT_WIDTH 16
`define CAP_WIDTH 32
`define BYTE_WIDTH 8
`define CNT_RESET 16'h0000
`define CAP_RESET 32'h0000_0000
`define FIRST_LO_LSB 0
`define FIRST_HI_LSB 8
`define SECOND_LO_LSB 16
`define SECOND_HI_LSB 24
`define REF_CLK_PERIOD_NS 40
`define SEL_IDLE_GAP_NS 200
`define SEL_IDLE_GAP_CYCLES ((`SEL_IDLE_GAP_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
`endif

// ---- rtl/dual_counter_pkg.sv ----
// Purpose: types for the dual counter with capture readout
// Assumes: nothing
// Notes: select group travels as one struct
package dual_counter_pkg;
  typedef struct packed {
    logic second_high_byte_sel_n;
    logic second_low_byte_sel_n;
    logic first_high_byte_sel_n;
    logic first_low_byte_sel_n;
  } byte_sel_s;
  typedef struct packed {
    logic [7:0] data;
    logic oe;
  } bus_out_s;
endpackage : dual_counter_pkg

// ---- rtl/dual_counter_capture_readout.sv ----
// Purpose: two 16-bit up counters, capture register, byte-wide readout
// Assumes: inputs other than rst and counter_clear_n synchronous to ref_clk; clocks sampled as edges
// Notes: count and capture clocks are edge-detected inputs, not clock domains
// Behaviour
// - two 16-bit counters, each on own clock
// - carry low while first counter full
// - second counter advances only with gate low
// - clear zeroes both counters at once
// - capture edge copies both counts together
// - stored value held until next capture
// - each half split into two bytes
// - four byte selects choose output byte
// - bus shows stored byte or floats
// - one select per byte; none floats
`timescale 1ns/1ps
`include "dual_counter_map.svh"
module dual_counter_capture_readout #(
  parameter int CNT_W = `CNT_WIDTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic count_clock_first,
  input wire logic count_clock_second,
  input wire logic capture_clock,
  input wire logic counter_clear_n,
  input wire logic second_count_gate_n,
  input wire dual_counter_pkg::byte_sel_s byte_sel,
  output logic first_carry_out_n,
  output logic [7:0] byte_read_bus_o,
  output logic byte_read_bus_oe,
  output logic sel_gap_violation
);
  import dual_counter_pkg::*;

  localparam int GAP_CYCLES = `SEL_IDLE_GAP_CYCLES;
  localparam int HALF_W = `CNT_WIDTH;

  logic first_clk_prev_reg;
  logic second_clk_prev_reg;
  logic cap_clk_prev_reg;
  logic [CNT_W-1:0] first_cnt_reg;
  logic [CNT_W-1:0] second_cnt_reg;
  logic [`CAP_WIDTH-1:0] capture_reg;
  bus_out_s bus_reg;
  bus_out_s bus_next;
  logic [7:0] idle_cnt_reg;
  logic gap_err_reg;
  logic first_edge;
  logic second_edge;
  logic cap_edge;
  logic [3:0] sel_low;
  logic sel_idle_prev_reg;
  logic read_start;

  function automatic logic [CNT_W-1:0] incr(input logic [CNT_W-1:0] v);
    incr = v + CNT_W'(1);
  endfunction : incr

  // rising edge of a sampled clock
  function automatic logic rise(input logic now_v, input logic prev_v);
    rise = now_v & ~prev_v;
  endfunction : rise

  // one storage half, zero-filled so byte positions stay fixed
  function automatic logic [HALF_W-1:0] widen(input logic [CNT_W-1:0] v);
    widen = HALF_W'(v);
  endfunction : widen

  assign first_edge = rise(count_clock_first, first_clk_prev_reg);
  assign second_edge = rise(count_clock_second, second_clk_prev_reg);
  assign cap_edge = rise(capture_clock, cap_clk_prev_reg);
  assign sel_low = ~byte_sel;
  assign read_start = (sel_low != 4'h0) && sel_idle_prev_reg;

  // edge history of the sampled clocks
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      first_clk_prev_reg <= 1'b0;
      second_clk_prev_reg <= 1'b0;
      cap_clk_prev_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      first_clk_prev_reg <= count_clock_first;
      second_clk_prev_reg <= count_clock_second;
      cap_clk_prev_reg <= capture_clock;
    end
  end

  // first counter, zeroed at once by the clear pin
  always_ff @(posedge ref_clk or posedge rst or negedge counter_clear_n)
  begin
    if (rst)
    begin
      first_cnt_reg <= CNT_W'(`CNT_RESET);
    end
    else if (!counter_clear_n)
    begin
      first_cnt_reg <= CNT_W'(`CNT_RESET);
    end
    else if (clk_en && first_edge)
    begin
      first_cnt_reg <= incr(first_cnt_reg);
    end
  end

  // second counter, gated, zeroed at once by the clear pin
  always_ff @(posedge ref_clk or posedge rst or negedge counter_clear_n)
  begin
    if (rst)
    begin
      second_cnt_reg <= CNT_W'(`CNT_RESET);
    end
    else if (!counter_clear_n)
    begin
      second_cnt_reg <= CNT_W'(`CNT_RESET);
    end
    else if (clk_en && second_edge && !second_count_gate_n)
    begin
      second_cnt_reg <= incr(second_cnt_reg);
    end
  end

  // carry from the live count so a clear lifts it at once
  always_comb
  begin
    first_carry_out_n = 1'b1;
    if (counter_clear_n && (&first_cnt_reg))
      first_carry_out_n = 1'b0;
  end

  // capture register
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      capture_reg <= `CAP_RESET;
    end
    else if (clk_en && cap_edge)
    begin
      capture_reg <= {widen(second_cnt_reg), widen(first_cnt_reg)};
    end
  end // otherwise held

  // byte mux
  always_comb
  begin
    bus_next = '0;
    unique case (sel_low)
      4'h1: bus_next = '{data: capture_reg[`FIRST_LO_LSB +: 8], oe: 1'b1};
      4'h2: bus_next = '{data: capture_reg[`FIRST_HI_LSB +: 8], oe: 1'b1};
      4'h4: bus_next = '{data: capture_reg[`SECOND_LO_LSB +: 8], oe: 1'b1};
      4'h8: bus_next = '{data: capture_reg[`SECOND_HI_LSB +: 8], oe: 1'b1};
      default: bus_next = '0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_reg <= '0;
    end
    else if (clk_en)
    begin
      bus_reg <= bus_next;
    end
  end

  assign byte_read_bus_o = bus_reg.data;
  assign byte_read_bus_oe = bus_reg.oe;

  // idle time of the selects, saturating at the gap length
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      idle_cnt_reg <= 8'(GAP_CYCLES);
    end
    else if (clk_en)
    begin
      if (sel_low != 4'h0)
      begin
        idle_cnt_reg <= 8'h00;
      end
      else if (idle_cnt_reg < 8'(GAP_CYCLES))
      begin
        idle_cnt_reg <= idle_cnt_reg + 8'h01;
      end
    end
  end

  // all-high history, marks the first cycle of a read
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sel_idle_prev_reg <= 1'b1;
    end
    else if (clk_en)
    begin
      sel_idle_prev_reg <= (sel_low == 4'h0);
    end
  end

  // sticky flag for a read that opens too early
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      gap_err_reg <= 1'b0;
    end
    else if (clk_en && read_start && (idle_cnt_reg < 8'(GAP_CYCLES)))
    begin
      gap_err_reg <= 1'b1;
    end
  end

  assign sel_gap_violation = gap_err_reg;
endmodule : dual_counter_capture_readout

// ---- sim/dual_counter_asserts.sv ----
// Purpose: port checks
// Assumes: clk_en high
// Notes: bound in testbench
`timescale 1ns/1ps
module dual_counter_asserts (
  input logic ref_clk,
  input logic rst,
  input logic count_clock_first,
  input logic capture_clock,
  input logic counter_clear_n,
  input dual_counter_pkg::byte_sel_s byte_sel,
  input logic first_carry_out_n,
  input logic [7:0] byte_read_bus_o,
  input logic byte_read_bus_oe
);
  import dual_counter_pkg::*;
  logic [5:0] h_reg;
  wire clk_seen = h_reg[0] | h_reg[2] | h_reg[4];
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) h_reg <= 6'h00;
    else h_reg <= {h_reg[3:0], capture_clock, count_clock_first};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_drv; $onehot(~byte_sel) |=> byte_read_bus_oe; endproperty
  a_drv: assert property (p_drv) else $error("no drive");
  property p_flt; !$onehot(~byte_sel) |=> !byte_read_bus_oe; endproperty
  a_flt: assert property (p_flt) else $error("no float");
  property p_src; byte_read_bus_oe |-> $past($onehot(~byte_sel)); endproperty
  a_src: assert property (p_src) else $error("bad oe");
  property p_hld; byte_read_bus_oe && $past(byte_read_bus_oe) && !h_reg[3]
    && $past(byte_sel) == $past(byte_sel, 2) |-> $stable(byte_read_bus_o); endproperty
  a_hld: assert property (p_hld) else $error("byte moved");
  property p_clr; !counter_clear_n |-> first_carry_out_n; endproperty
  a_clr: assert property (p_clr) else $error("carry on clear");
  property p_fal; $fell(first_carry_out_n) |-> clk_seen; endproperty
  a_fal: assert property (p_fal) else $error("carry fell");
  property p_ris; $rose(first_carry_out_n) |-> clk_seen || !counter_clear_n; endproperty
  a_ris: assert property (p_ris) else $error("carry rose");
  property p_low; !first_carry_out_n && counter_clear_n && !h_reg[0] && !count_clock_first
    |=> !first_carry_out_n || !counter_clear_n; endproperty
  a_low: assert property (p_low) else $error("carry lost");
  c_rd: cover property (byte_read_bus_oe);
  c_cy: cover property (!first_carry_out_n);
  c_cap: cover property ($rose(capture_clock));
endmodule : dual_counter_asserts

// ---- sim/host_reader.sv ----
// Purpose: host byte reader
// Assumes: one request at a time
// Notes: idle selects driven high
`timescale 1ns/1ps
module host_reader (
  input logic req,
  input logic [1:0] idx,
  input logic dual,
  output dual_counter_pkg::byte_sel_s sel
);
  assign sel = !req ? 4'hF : (dual ? 4'hC : ~(4'h1 << idx));
endmodule : host_reader

// ---- sim/testbench.sv ----
// Purpose: dual counter bench
// Assumes: CNT_W 4 shortens wrap
// Notes: host_reader drives selects
`timescale 1ns/1ps
module testbench;
  import dual_counter_pkg::*;
  logic ref_clk = 0, rst = 1, ca = 0, cb = 0, cap = 0, clr_n = 1, gate_n = 1;
  logic chain = 0, req = 0, dual = 0, carry_n, oe, gap;
  logic [1:0] idx = 0;
  logic [3:0] ea = 0, eb = 0;
  logic [7:0] bus;
  logic [31:0] word;
  byte_sel_s sel;
  int bad_count = 0, cmp_count = 0;
  always #20 ref_clk = ~ref_clk;
  host_reader host_u (.req(req), .idx(idx), .dual(dual), .sel(sel));
  dual_counter_capture_readout #(.CNT_W(4)) dut_u (.ref_clk, .rst, .clk_en(1'b1),
    .count_clock_first(ca), .count_clock_second(cb), .capture_clock(cap),
    .counter_clear_n(clr_n), .second_count_gate_n(chain ? carry_n : gate_n),
    .byte_sel(sel), .first_carry_out_n(carry_n), .byte_read_bus_o(bus),
    .byte_read_bus_oe(oe), .sel_gap_violation(gap));
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic pulse(input logic a, b, input int n);
    repeat (n)
    begin
      @(posedge ref_clk) ca <= a;
      cb <= b;
      @(posedge ref_clk) ca <= 0;
      cb <= 0;
    end
    repeat (2) @(posedge ref_clk);
  endtask : pulse
  task automatic snap;
    @(posedge ref_clk) cap <= 1;
    @(posedge ref_clk) cap <= 0;
    word = {12'h000, eb, 12'h000, ea};
    repeat (2) @(posedge ref_clk);
  endtask : snap
  task automatic read_all;
    for (int i = 0; i < 4; i++)
    begin
      repeat (6) @(posedge ref_clk);
      req <= 1;
      idx <= i[1:0];
      repeat (2) @(posedge ref_clk);
      #1 chk("oe", {7'h00, oe}, 8'h01);
      chk("byte", bus, word[8*i+:8]);
      @(posedge ref_clk) req <= 0;
    end
  endtask : read_all
  task automatic t_basic;
    pulse(1, 0, 3);
    gate_n <= 0;
    pulse(0, 1, 2);
    gate_n <= 1;
    pulse(0, 1, 1);
    {ea, eb} = {4'h3, 4'h2};
    snap();
    read_all();
  endtask : t_basic
  task automatic t_hold;
    pulse(1, 0, 5);
    read_all();
    ea = 4'h8;
    snap();
    read_all();
  endtask : t_hold
  task automatic t_chain;
    @(posedge ref_clk) clr_n <= 0;
    chain <= 1;
    repeat (2) @(posedge ref_clk);
    @(posedge ref_clk) clr_n <= 1;
    pulse(1, 1, 15);
    #1 chk("carry", {7'h00, carry_n}, 8'h00);
    pulse(1, 1, 5);
    {ea, eb} = {4'h4, 4'h1};
    snap();
    read_all();
  endtask : t_chain
  task automatic t_gap;
    #1 chk("gap", {7'h00, gap}, 8'h00);
    repeat (6) @(posedge ref_clk);
    req <= 1;
    dual <= 1;
    repeat (2) @(posedge ref_clk);
    #1 chk("dual", {7'h00, oe}, 8'h00);
    chk("gap", {7'h00, gap}, 8'h00);
    @(posedge ref_clk) req <= 0;
    dual <= 0;
    repeat (2) @(posedge ref_clk);
    req <= 1;
    repeat (2) @(posedge ref_clk);
    #1 chk("gap", {7'h00, gap}, 8'h01);
    @(posedge ref_clk) req <= 0;
    repeat (2) @(posedge ref_clk);
  endtask : t_gap
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 0;
    t_basic();
    t_hold();
    t_chain();
    t_gap();
    report_and_stop();
  end
endmodule : testbench
bind dual_counter_capture_readout dual_counter_asserts chk_u (.ref_clk, .rst,
  .count_clock_first, .capture_clock, .counter_clear_n, .byte_sel,
  .first_carry_out_n, .byte_read_bus_o, .byte_read_bus_oe);
